// ### rtl/warn_pkg.sv
/*
  Constants, types and register map of the drive warning reporter.
  Assumes a single 100 MHz clock domain and an APB master on that clock.
*/
`default_nettype none
package warn_pkg;
  localparam int NWARN = 15;
  // Register byte offsets
  localparam logic [7:0] OFS_EXCESS_LVL  = 8'h00;
  localparam logic [7:0] OFS_WARN_PCT    = 8'h04;
  localparam logic [7:0] OFS_SON_LVL     = 8'h08;
  localparam logic [7:0] OFS_SON_PCT     = 8'h0C;
  localparam logic [7:0] OFS_VIB_SEL     = 8'h10;
  localparam logic [7:0] OFS_OH_LVL      = 8'h14;
  localparam logic [7:0] OFS_BASIC_B     = 8'h18;
  localparam logic [7:0] OFS_RIPPLE_SEL  = 8'h1C;
  localparam logic [7:0] OFS_OT_SEL      = 8'h20;
  localparam logic [7:0] OFS_MAINT_SEL   = 8'h24;
  localparam logic [7:0] OFS_STATUSWORD  = 8'h28;
  localparam logic [7:0] OFS_ERROR_CODE  = 8'h2C;
  localparam logic [7:0] OFS_CONTROLWORD = 8'h30;
  localparam logic [7:0] OFS_ACTIVE      = 8'h34;
  // Field positions and values
  localparam int         WARN_BIT       = 7;
  localparam int         FAULT_RST_BIT  = 7;
  localparam logic [3:0] GEN_DETECT     = 4'h0;
  localparam logic [3:0] VIB_WARN       = 4'h1;
  localparam logic [3:0] BATT_WARN      = 4'h1;
  localparam logic [3:0] RIPPLE_DETECT  = 4'h0;
  localparam logic [3:0] UV_WARN        = 4'h1;
  localparam logic [3:0] OT_WARN        = 4'h1;
  localparam logic [3:0] MAINT_WARN     = 4'h1;
  // Reset values
  localparam logic [31:0] RST_EXCESS_LVL = 32'h0000_1000;
  localparam logic [15:0] RST_PCT        = 16'h0064;
  localparam logic [15:0] RST_SEL        = 16'h0000;
  localparam logic [15:0] RST_OH_LVL     = 16'h0100;
  // Warning codes, index 0 is 900h
  localparam logic [NWARN-1:0][15:0] WARN_CODES = {
    16'h09B0, 16'h09A0, 16'h0971, 16'h0942, 16'h093B, 16'h0930, 16'h0923, 16'h0921,
    16'h0920, 16'h0913, 16'h0912, 16'h0911, 16'h0910, 16'h0901, 16'h0900};
  localparam logic [15:0] NO_CODE = 16'h0000;
  // Panel timing
  localparam int CHAR_TIME_MS = 500;
  localparam int CLK_KHZ      = 100000;
  // Panel characters
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_BLANK = 8'h20;

  typedef struct packed {
    logic [31:0] pos_deviation;
    logic        servo_on;
    logic        overload_pre;
    logic        vibration;
    logic        ctrl_temp_abn;
    logic        power_temp_abn;
    logic        regen_pre;
    logic        dbrake_pre;
    logic        fan_stopped;
    logic        battery_low;
    logic [15:0] overheat_protect_input;
    logic        ripple_mismatch;
    logic        undervoltage_pre;
    logic        overtravel;
    logic        life_end;
  } monitor_s;

  typedef enum logic [5:0] {
    DISP_IDLE = 6'b000001,
    DISP_A    = 6'b000010,
    DISP_DOT  = 6'b000100,
    DISP_D2   = 6'b001000,
    DISP_D1   = 6'b010000,
    DISP_D0   = 6'b100000
  } disp_e;
endpackage : warn_pkg
`default_nettype wire

// ### rtl/drive_warning_reporter.sv
/*
  Warning detection and reporting: APB parameter/status registers,
  warning latch, error code, emergency message and panel display.
  Assumes monitor inputs come from logic on pclk.
*/
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module drive_warning_reporter
  import warn_pkg::*;
#(
  parameter int CHAR_CYCLES = CHAR_TIME_MS * CLK_KHZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire monitor_s    mon,
  input  wire logic        emcy_ready,
  output logic             emcy_valid,
  output logic      [15:0] emcy_code,
  output logic             warn_bit,
  output logic      [15:0] error_code,
  output logic      [7:0]  panel_char
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic exceeds(input logic [31:0] dev, input logic [31:0] lvl,
                                   input logic [15:0] pct);
    logic [47:0] lhs;
    logic [47:0] rhs;
    lhs = 48'(dev) * 48'h64;
    rhs = 48'(lvl) * 48'(pct);
    return lhs > rhs;
  endfunction : exceeds

  function automatic logic [7:0] hex_char(input logic [3:0] d);
    return (d < 4'hA) ? (8'h30 + 8'(d)) : (8'h57 + 8'(d));
  endfunction : hex_char

  // True when code belongs to a warning whose active bit is set
  function automatic logic code_live(input logic [15:0] code, input logic [NWARN-1:0] act);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NWARN; i++) begin
      if (act[i] && WARN_CODES[i] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : code_live

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic [31:0] excess_lvl_r;
  logic [15:0] warn_pct_r;
  logic [31:0] son_lvl_r;
  logic [15:0] son_pct_r;
  logic [15:0] vib_sel_r;
  logic [15:0] oh_lvl_r;
  logic [15:0] basic_b_r;
  logic [15:0] ripple_sel_r;
  logic [15:0] ot_sel_r;
  logic [15:0] maint_sel_r;
  logic [NWARN-1:0] active_r;
  logic [15:0] last_code_r;
  logic        acc;
  logic        wr;
  logic        fault_reset;
  logic        mapped;

  assign acc         = psel & penable & pready;
  assign wr          = acc & pwrite & ~pslverr;
  assign fault_reset = wr && paddr == OFS_CONTROLWORD && pwdata[FAULT_RST_BIT];

  always_comb begin
    case (paddr)
      OFS_EXCESS_LVL, OFS_WARN_PCT, OFS_SON_LVL, OFS_SON_PCT, OFS_VIB_SEL, OFS_OH_LVL,
      OFS_BASIC_B, OFS_RIPPLE_SEL, OFS_OT_SEL, OFS_MAINT_SEL, OFS_STATUSWORD,
      OFS_ERROR_CODE, OFS_CONTROLWORD, OFS_ACTIVE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          OFS_EXCESS_LVL: prdata <= excess_lvl_r;
          OFS_WARN_PCT:   prdata <= {16'h0000, warn_pct_r};
          OFS_SON_LVL:    prdata <= son_lvl_r;
          OFS_SON_PCT:    prdata <= {16'h0000, son_pct_r};
          OFS_VIB_SEL:    prdata <= {16'h0000, vib_sel_r};
          OFS_OH_LVL:     prdata <= {16'h0000, oh_lvl_r};
          OFS_BASIC_B:    prdata <= {16'h0000, basic_b_r};
          OFS_RIPPLE_SEL: prdata <= {16'h0000, ripple_sel_r};
          OFS_OT_SEL:     prdata <= {16'h0000, ot_sel_r};
          OFS_MAINT_SEL:  prdata <= {16'h0000, maint_sel_r};
          OFS_STATUSWORD: prdata <= {24'h00_0000, warn_bit, 7'h00};
          OFS_ERROR_CODE: prdata <= {16'h0000, error_code};
          OFS_ACTIVE:     prdata <= {17'h0_0000, active_r};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      excess_lvl_r <= RST_EXCESS_LVL;
      warn_pct_r   <= RST_PCT;
      son_lvl_r    <= RST_EXCESS_LVL;
      son_pct_r    <= RST_PCT;
      vib_sel_r    <= RST_SEL;
      oh_lvl_r     <= RST_OH_LVL;
      basic_b_r    <= RST_SEL;
      ripple_sel_r <= RST_SEL;
      ot_sel_r     <= RST_SEL;
      maint_sel_r  <= RST_SEL;
    end else if (wr) begin
      case (paddr)
        OFS_EXCESS_LVL: excess_lvl_r <= pwdata;
        OFS_WARN_PCT:   warn_pct_r   <= pwdata[15:0];
        OFS_SON_LVL:    son_lvl_r    <= pwdata;
        OFS_SON_PCT:    son_pct_r    <= pwdata[15:0];
        OFS_VIB_SEL:    vib_sel_r    <= pwdata[15:0];
        OFS_OH_LVL:     oh_lvl_r     <= pwdata[15:0];
        OFS_BASIC_B:    basic_b_r    <= pwdata[15:0];
        OFS_RIPPLE_SEL: ripple_sel_r <= pwdata[15:0];
        OFS_OT_SEL:     ot_sel_r     <= pwdata[15:0];
        OFS_MAINT_SEL:  maint_sel_r  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------
  logic             servo_on_d_r;
  logic             gen_en;
  logic [NWARN-1:0] cond;
  logic [NWARN-1:0] cond_d_r;
  logic [NWARN-1:0] rise;

  assign gen_en = basic_b_r[11:8] == GEN_DETECT;

  always_comb begin
    cond[0]  = gen_en & exceeds(mon.pos_deviation, excess_lvl_r, warn_pct_r);
    cond[1]  = gen_en & mon.servo_on & ~servo_on_d_r
             & exceeds(mon.pos_deviation, son_lvl_r, son_pct_r);
    cond[2]  = gen_en & mon.overload_pre;
    cond[3]  = gen_en & mon.vibration & (vib_sel_r[3:0] == VIB_WARN);
    cond[4]  = gen_en & mon.ctrl_temp_abn;
    cond[5]  = gen_en & mon.power_temp_abn;
    cond[6]  = gen_en & mon.regen_pre;
    cond[7]  = gen_en & mon.dbrake_pre;
    cond[8]  = gen_en & mon.fan_stopped;
    cond[9]  = gen_en & mon.battery_low & (basic_b_r[3:0] == BATT_WARN);
    cond[10] = gen_en & (mon.overheat_protect_input > oh_lvl_r);
    cond[11] = gen_en & mon.ripple_mismatch & (ripple_sel_r[7:4] == RIPPLE_DETECT);
    cond[12] = mon.undervoltage_pre & (basic_b_r[7:4] == UV_WARN);
    cond[13] = mon.overtravel & mon.servo_on & (ot_sel_r[15:12] == OT_WARN);
    cond[14] = gen_en & mon.life_end & (maint_sel_r[3:0] == MAINT_WARN);
  end

  assign rise = cond & ~cond_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_on_d_r <= 1'b0;
      cond_d_r     <= '0;
    end else begin
      servo_on_d_r <= mon.servo_on;
      cond_d_r     <= cond;
    end
  end

  // ----------------------------------------------------------------
  // Warning latch and error code
  // ----------------------------------------------------------------
  logic [NWARN-1:0] active_nxt;
  logic [15:0]      code_nxt;

  // Falls back to a still active code once the latest one is cleared
  always_comb begin
    code_nxt = last_code_r;
    if (!code_live(last_code_r, active_nxt)) begin
      for (int i = 0; i < NWARN; i++) begin
        if (active_nxt[i]) begin
          code_nxt = WARN_CODES[i];
        end
      end
    end
    for (int i = 0; i < NWARN; i++) begin
      if (rise[i]) begin
        code_nxt = WARN_CODES[i];
      end
    end
  end

  // Set wins over fault reset
  assign active_nxt = (fault_reset ? '0 : active_r) | cond;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r    <= '0;
      last_code_r <= NO_CODE;
      warn_bit    <= 1'b0;
      error_code  <= NO_CODE;
    end else begin
      active_r    <= active_nxt;
      last_code_r <= code_nxt;
      warn_bit    <= |active_nxt;
      error_code  <= (|active_nxt) ? code_nxt : NO_CODE;
    end
  end

  // ----------------------------------------------------------------
  // Emergency message
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emcy_valid <= 1'b0;
      emcy_code  <= NO_CODE;
    end else if (|rise) begin
      emcy_valid <= 1'b1;
      emcy_code  <= code_nxt;
    end else if (emcy_ready) begin
      emcy_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Panel display
  // ----------------------------------------------------------------
  disp_e       disp_r;
  logic [31:0] char_cnt_r;
  logic        char_done;

  assign char_done = char_cnt_r == 32'(CHAR_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      char_cnt_r <= 32'h0000_0000;
    end else if (disp_r == DISP_IDLE || char_done) begin
      char_cnt_r <= 32'h0000_0000;
    end else begin
      char_cnt_r <= char_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_r     <= DISP_IDLE;
      panel_char <= CH_BLANK;
    end else begin
      case (disp_r)
        DISP_IDLE: begin
          panel_char <= CH_BLANK;
          if (warn_bit) begin
            disp_r     <= DISP_A;
            panel_char <= CH_A;
          end
        end
        DISP_A: if (char_done) begin
          disp_r     <= DISP_DOT;
          panel_char <= CH_DOT;
        end
        DISP_DOT: if (char_done) begin
          disp_r     <= DISP_D2;
          panel_char <= hex_char(error_code[11:8]);
        end
        DISP_D2: if (char_done) begin
          disp_r     <= DISP_D1;
          panel_char <= hex_char(error_code[7:4]);
        end
        DISP_D1: if (char_done) begin
          disp_r     <= DISP_D0;
          panel_char <= hex_char(error_code[3:0]);
        end
        DISP_D0: if (char_done) begin
          disp_r     <= DISP_IDLE;
          panel_char <= CH_BLANK;
        end
        default: begin
          disp_r     <= DISP_IDLE;
          panel_char <= CH_BLANK;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  warn_bit_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|cond) |=> warn_bit) else $error("warning bit not set");
  warn_bit_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!fault_reset && active_r == '0 && cond == '0) |=> !warn_bit)
    else $error("warning bit set without warning");
  code_latest_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rise[0] && rise[14:1] == '0) |=> error_code == WARN_CODES[0])
    else $error("error code not latest");
  code_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !warn_bit |-> error_code == NO_CODE) else $error("stale error code");
  code_live_a: assert property (@(posedge pclk) disable iff (!presetn)
    warn_bit |-> code_live(error_code, active_r)) else $error("error code not active");
  emcy_sent_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|rise) |=> emcy_valid && emcy_code == $past(code_nxt))
    else $error("emergency not sent");
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_reset |=> active_r == $past(cond)) else $error("set lost to clear");
  clear_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_reset && cond == '0) |=> active_r == '0) else $error("fault reset ignored");
  uv_indep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mon.undervoltage_pre && basic_b_r[7:4] == UV_WARN) |=> warn_bit && active_r[12])
    else $error("undervoltage gated wrongly");
  ot_servo_a: assert property (@(posedge pclk) disable iff (!presetn)
    !mon.servo_on |-> !cond[13]) else $error("overtravel without servo on");
  vib_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (vib_sel_r[3:0] != VIB_WARN) |-> !cond[3]) else $error("vibration not gated");
  panel_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (disp_r == DISP_IDLE && warn_bit) |=> panel_char == CH_A ##0 disp_r == DISP_A)
    else $error("panel did not start");
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("apb answer timing");

  warn_cov_c:  cover property (@(posedge pclk) disable iff (!presetn) $rose(warn_bit));
  multi_cov_c: cover property (@(posedge pclk) disable iff (!presetn) rise[0] ##[1:20] rise[2]);
  clr_cov_c:   cover property (@(posedge pclk) disable iff (!presetn) warn_bit && fault_reset);
  panel_cov_c: cover property (@(posedge pclk) disable iff (!presetn) disp_r == DISP_D0);

endmodule : drive_warning_reporter
`default_nettype wire

// ### dv/host_model.sv
/*
  Host controller model on the emergency message channel.
  Assumes emcy_valid and emcy_code are registered on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        emcy_valid,
  input  wire logic [15:0] emcy_code,
  output logic             emcy_ready,
  output logic      [15:0] last_code,
  output int               n_msg
);
  int wait_r;

  // Accepts after 0 to 3 cycles; takes the code at the handshake edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emcy_ready <= 1'b0;
      wait_r     <= 0;
      last_code  <= 16'h0000;
      n_msg      <= 0;
    end else if (emcy_valid && emcy_ready) begin
      emcy_ready <= 1'b0;
      last_code  <= emcy_code;
      n_msg      <= n_msg + 1;
    end else if (emcy_valid && wait_r == 0) begin
      emcy_ready <= 1'b1;
    end else if (emcy_valid) begin
      wait_r <= wait_r - 1;
    end else begin
      wait_r <= int'($urandom_range(3, 0));
    end
  end
endmodule : host_model
`default_nettype wire

// ### dv/tb.sv
/*
  Self-checking bench for the drive warning reporter.
  Assumes a short panel character time and the host model on the emergency channel.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import warn_pkg::*;
  localparam int CC = 4;
  logic        pclk         = 1'b0;
  logic        presetn      = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [7:0]  paddr        = 8'h00;
  logic [31:0] pwdata       = 32'h0;
  monitor_s    mon          = '0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, err, emcy_ready, emcy_valid, warn_bit;
  logic [15:0] emcy_code, error_code, last_code;
  logic [15:0] basic_s, vib_s, rip_s, ot_s, maint_s;
  logic [7:0]  panel_char;
  int          n_msg;
  int          n_mismatch   = 0;
  int          total_checks = 0;

  drive_warning_reporter #(.CHAR_CYCLES(CC)) drive_warning_reporter_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mon(mon), .emcy_ready(emcy_ready), .emcy_valid(emcy_valid), .emcy_code(emcy_code),
    .warn_bit(warn_bit), .error_code(error_code), .panel_char(panel_char));
  host_model host_model_i (
    .pclk(pclk), .presetn(presetn), .emcy_valid(emcy_valid), .emcy_code(emcy_code),
    .emcy_ready(emcy_ready), .last_code(last_code), .n_msg(n_msg));

  always #5 pclk = ~pclk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo();
    chk(32'h0, 32'h1);
    stop_test();
  endtask : tmo

  task automatic tick(input int n = 1);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic setc(input int k, input logic [31:0] v);
    @(posedge pclk);
    case (k)
      0:       mon.pos_deviation <= v;
      2:       mon.overload_pre <= v[0];
      3:       mon.vibration <= v[0];
      4:       mon.ctrl_temp_abn <= v[0];
      5:       mon.power_temp_abn <= v[0];
      6:       mon.regen_pre <= v[0];
      7:       mon.dbrake_pre <= v[0];
      8:       mon.fan_stopped <= v[0];
      9:       mon.battery_low <= v[0];
      10:      mon.overheat_protect_input <= v[15:0];
      11:      mon.ripple_mismatch <= v[0];
      12:      mon.undervoltage_pre <= v[0];
      13:      mon.overtravel <= v[0];
      default: mon.life_end <= v[0];
    endcase
  endtask : setc

  function automatic logic [7:0] hexch(input logic [3:0] d);
    return (d < 4'hA) ? 8'h30 + 8'(d) : 8'h57 + 8'(d);
  endfunction : hexch

  function automatic logic exp_en(input int k);
    logic g;
    g = (basic_s[11:8] == 4'h0);
    case (k)
      3:       return g && vib_s[3:0] == 4'h1;
      9:       return g && basic_s[3:0] == 4'h1;
      11:      return g && rip_s[7:4] == 4'h0;
      12:      return basic_s[7:4] == 4'h1;
      13:      return ot_s[15:12] == 4'h1;
      14:      return g && maint_s[3:0] == 4'h1;
      default: return g;
    endcase
  endfunction : exp_en

  task automatic panel_chk(input logic [15:0] c);
    logic [7:0] e [5];
    int n;
    e = '{CH_A, CH_DOT, hexch(c[11:8]), hexch(c[7:4]), hexch(c[3:0])};
    for (n = 0; n < 40 && panel_char !== CH_A; n++) tick();
    if (panel_char !== CH_A) tmo();
    for (n = 0; n < 5; n++) begin
      chk({24'h0, panel_char}, {24'h0, e[n]});
      tick(CC);
    end
  endtask : panel_chk

  task automatic fault_reset();
    wr(OFS_CONTROLWORD, 32'h0000_0080);
    tick(2);
  endtask : fault_reset

  // Raise one condition, check every report path, then clear it
  task automatic trial(input int k, input logic [31:0] v, input logic ex);
    int m0;
    int n;
    m0 = n_msg;
    setc(k, v);
    tick(2);
    chk({31'h0, warn_bit}, {31'h0, ex});
    chk({16'h0, error_code}, ex ? {16'h0, WARN_CODES[k]} : 32'h0);
    if (ex) panel_chk(WARN_CODES[k]);
    for (n = 0; n < 20 && ex && n_msg == m0; n++) tick();
    if (ex && n_msg == m0) tmo();
    chk(32'(n_msg - m0), {31'h0, ex});
    if (ex) chk({16'h0, last_code}, {16'h0, WARN_CODES[k]});
    apb(1'b0, OFS_STATUSWORD, 32'h0);
    chk({31'h0, q[WARN_BIT]}, {31'h0, ex});
    setc(k, 32'h0);
    fault_reset();
    chk({31'h0, warn_bit}, 32'h0);
  endtask : trial

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int i;
    int k;
    logic [31:0] lvl, pct, dev, ex;
    void'($urandom(13445));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 14; i++) begin
      ex = (i == 0 || i == 2) ? RST_EXCESS_LVL : (i == 1 || i == 3) ? {16'h0, RST_PCT} : 32'h0;
      if (i == 5) ex = {16'h0, RST_OH_LVL};
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, ex);
    end
    apb(1'b0, 8'h38, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(OFS_ERROR_CODE, 32'hFFFF_FFFF);
    apb(1'b0, OFS_ERROR_CODE, 32'h0);
    chk(q, 32'h0);
    wr(OFS_OH_LVL, 32'hFFFF_0123);
    apb(1'b0, OFS_OH_LVL, 32'h0);
    chk(q, 32'h0000_0123);
    trial(10, 32'h0000_0123, 1'b0);
    trial(10, 32'h0000_0124, 1'b1);
    $display("test registers done");
    wr(OFS_EXCESS_LVL, 32'h0010_0000);
    for (i = 0; i < 2; i++) begin
      @(posedge pclk);
      mon.servo_on      <= 1'b0;
      mon.pos_deviation <= 32'h0000_1000 + 32'(i);
      @(posedge pclk);
      mon.servo_on <= 1'b1;
      tick(2);
      chk({16'h0, error_code}, (i == 1) ? {16'h0, WARN_CODES[1]} : 32'h0);
      setc(0, 32'h0);
      fault_reset();
    end
    $display("test servo on done");
    for (i = 0; i < 6; i++) begin
      lvl = $urandom_range(32'hFFFF, 32'h100);
      pct = $urandom_range(100, 1);
      wr(OFS_EXCESS_LVL, lvl);
      wr(OFS_WARN_PCT, pct);
      dev = (lvl * pct) / 100 + 32'(i % 3) - 32'h1;
      trial(0, dev, (dev * 100) > (lvl * pct));
    end
    $display("test deviation done");
    {basic_s, vib_s, rip_s, ot_s, maint_s} = '0;
    for (i = 0; i < 3; i++) begin
      if (i == 1) {basic_s, vib_s, rip_s, ot_s, maint_s} = {16'h0011, 16'h1, 16'h0010, 16'h1000, 16'h1};
      if (i == 2) basic_s = 16'h0111;
      wr(OFS_BASIC_B, {16'h0, basic_s});
      wr(OFS_VIB_SEL, {16'h0, vib_s});
      wr(OFS_RIPPLE_SEL, {16'h0, rip_s});
      wr(OFS_OT_SEL, {16'h0, ot_s});
      wr(OFS_MAINT_SEL, {16'h0, maint_s});
      for (k = 2; k < 7; k++) trial(k, 32'h1, exp_en(k));
      for (k = 7; k < 10; k++) trial(k, 32'h1, exp_en(k));
      trial(10, 32'h0000_FFFF, exp_en(10));
      for (k = 11; k < 15; k++) trial(k, 32'h1, exp_en(k));
    end
    $display("test selection done");
    wr(OFS_BASIC_B, 32'h0);
    setc(8, 32'h1);
    tick(2);
    setc(2, 32'h1);
    tick(2);
    chk({16'h0, error_code}, {16'h0, WARN_CODES[2]});
    fault_reset();
    chk({31'h0, warn_bit}, 32'h1);
    apb(1'b0, OFS_ACTIVE, 32'h0);
    chk(q, 32'h0000_0104);
    setc(2, 32'h0);
    fault_reset();
    chk({16'h0, error_code}, {16'h0, WARN_CODES[8]});
    apb(1'b0, OFS_ERROR_CODE, 32'h0);
    chk(q, {16'h0, WARN_CODES[8]});
    setc(8, 32'h0);
    fault_reset();
    chk({31'h0, warn_bit}, 32'h0);
    $display("test several warnings done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
